// file: logic/serdes_tx_lane_level_ctrl.sv
/*
  Per-lane transmitter drive level and fine de-emphasis storage for twelve
  serdes quads, with an AXI4-Lite slave and registered driver settings.
  Assumes one clock, synchronous inputs and the link controller supplying
  each quad's rate and de-emphasis select.
*/
`timescale 1ns/1ps
`include "serdes_tx_lane_level_params.svh"

module serdes_tx_lane_level_ctrl
  import serdes_tx_lane_level_pkg::*;
(
  input  wire logic                                aclk,              // clock
  input  wire logic                                aresetn,           // sync reset
  input  wire logic [`ADDR_W-1:0]                  awaddr,            // write address
  input  wire logic                                awvalid,           // write addr valid
  output logic                                     awready,           // write addr ready
  input  wire logic [31:0]                         wdata,             // write data
  input  wire logic [3:0]                          wstrb,             // byte strobes
  input  wire logic                                wvalid,            // write data valid
  output logic                                     wready,            // write data ready
  output logic [1:0]                               bresp,             // write response
  output logic                                     bvalid,            // response valid
  input  wire logic                                bready,            // response ready
  input  wire logic [`ADDR_W-1:0]                  araddr,            // read address
  input  wire logic                                arvalid,           // read addr valid
  output logic                                     arready,           // read addr ready
  output logic [31:0]                              rdata,             // read data
  output logic [1:0]                               rresp,             // read response
  output logic                                     rvalid,            // read valid
  input  wire logic                                rready,            // read ready
  input  wire logic [`NUM_SLOTS-1:0]               rate_gen2,         // per quad second rate
  input  wire logic [`NUM_SLOTS-1:0]               deemph_sel_strong, // 1 = -6.0dB select
  output logic [`NUM_SLOTS*`NUM_LANES*5-1:0]       drv_level,         // lane drive level
  output logic [`NUM_SLOTS*`NUM_LANES*3-1:0]       drv_fine_deemph,   // lane fine de-emphasis
  output logic [`NUM_SLOTS-1:0]                    drv_deemph_en      // de-emphasis on
);

  state_s q, d;

  // {valid, is_ctl, slot}; quads 12 and 13 fold onto slots 10 and 11
  function automatic logic [5:0] decode(input logic [`ADDR_W-1:0] a);
    logic [3:0] idx;
    logic       ok;
    idx = a[7:4];
    ok  = (a[3] == 1'b0) && (a[1:0] == 2'h0);
    if (idx <= 4'h9) begin
      return {ok, a[2], idx};
    end else if (idx == 4'hc || idx == 4'hd) begin
      return {ok, a[2], idx - 4'h2};
    end else begin
      return 6'h00;
    end
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic state_s reset_state();
    state_s s;
    s = '0;
    for (int i = 0; i < `NUM_SLOTS; i++) begin
      s.qctl[i] = `RST_QCTL;
      for (int l = 0; l < `NUM_LANES; l++) begin
        s.cfg[i][l] = {`RST_FS_LVL_R2S, `RST_FDE_R2M, `RST_FS_LVL_R2M,
                       `RST_FDE_R1, `RST_FS_LVL_R1};
      end
    end
    return s;
  endfunction : reset_state

  assign awready = !q.aw_hold && !q.bvalid;
  assign wready  = !q.w_hold && !q.bvalid;
  assign arready = !q.rvalid;

  always_comb begin
    logic [5:0]  wdec;
    logic [5:0]  rdec;
    logic [3:0]  sel;
    logic [31:0] m;
    lane_cfg_t   c;
    wdec  = decode(q.aw_addr);
    rdec  = decode(araddr);
    sel   = 4'h0;
    m     = 32'h0;
    c     = '0;
    d     = q;
    if (awvalid && awready) begin
      d.aw_hold = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_hold = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      d.aw_hold = 1'b0;
      d.w_hold  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wdec[5] ? `RESP_OKAY : `RESP_SLVERR;
      if (wdec[5] && wdec[4]) begin
        m = merge({27'h0, q.qctl[wdec[3:0]]}, q.w_data, q.w_strb);
        d.qctl[wdec[3:0]] = m[`QCTL_W-1:0];
      end else if (wdec[5]) begin
        sel = q.qctl[wdec[3:0]][`QCTL_LANE_SEL_HI:`QCTL_LANE_SEL_LO];
        for (int l = 0; l < `NUM_LANES; l++) begin
          if (sel[l]) begin
            m = merge({11'h0, q.cfg[wdec[3:0]][l]}, q.w_data, q.w_strb);
            d.cfg[wdec[3:0]][l] = m[`LANE_CFG_W-1:0];
          end
        end
      end
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rresp  = rdec[5] ? `RESP_OKAY : `RESP_SLVERR;
      d.rdata  = 32'h0;
      if (rdec[5] && rdec[4]) begin
        d.rdata = {27'h0, q.qctl[rdec[3:0]]};
      end else if (rdec[5]) begin
        sel = q.qctl[rdec[3:0]][`QCTL_LANE_SEL_HI:`QCTL_LANE_SEL_LO];
        c   = q.cfg[rdec[3:0]][0];
        // reads show the lowest selected lane, lane 0 when none is selected
        for (int l = `NUM_LANES - 1; l >= 0; l--) begin
          if (sel[l]) begin
            c     = q.cfg[rdec[3:0]][l];
          end
        end
        d.rdata = {11'h0, c};
      end
    end
    for (int s = 0; s < `NUM_SLOTS; s++) begin
      d.de_en[s] = !q.qctl[s][`QCTL_LOW_SWING];
      for (int l = 0; l < `NUM_LANES; l++) begin
        c = q.cfg[s][l];
        if (q.qctl[s][`QCTL_LOW_SWING]) begin
          d.level[s][l] = 5'h00;
          d.fine[s][l]  = 3'h0;
        end else if (!rate_gen2[s]) begin
          d.level[s][l] = c[`FS_LVL_R1_HI:`FS_LVL_R1_LO];
          d.fine[s][l]  = c[`FDE_R1_HI:`FDE_R1_LO];
        end else if (!deemph_sel_strong[s]) begin
          d.level[s][l] = c[`FS_LVL_R2M_HI:`FS_LVL_R2M_LO];
          d.fine[s][l]  = c[`FDE_R2M_HI:`FDE_R2M_LO];
        end else begin
          d.level[s][l] = c[`FS_LVL_R2S_HI:`FS_LVL_R2S_LO];
          d.fine[s][l]  = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= reset_state();
    end else begin
      q <= d;
    end
  end

  assign bvalid          = q.bvalid;
  assign bresp           = q.bresp;
  assign rvalid          = q.rvalid;
  assign rdata           = q.rdata;
  assign rresp           = q.rresp;
  assign drv_level       = q.level;
  assign drv_fine_deemph = q.fine;
  assign drv_deemph_en   = q.de_en;

  // checks on quad slot 0, lane 0, and refusal of quad 10 reads
  wire logic      ls0  = q.qctl[0][`QCTL_LOW_SWING];
  wire lane_cfg_t c00  = q.cfg[0][0];
  // only mapped lane-register writes to quad 0 commit
  wire logic      wr0  = q.aw_hold && q.w_hold && !q.bvalid && !q.aw_addr[2]
                         && !q.aw_addr[3] && (q.aw_addr[1:0] == 2'h0)
                         && (q.aw_addr[7:4] == 4'h0);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_r1_level;
    aresetn && !ls0 && !rate_gen2[0] |=> q.level[0][0] == $past(c00[4:0]);
  endproperty
  a_r1_level: assert property (p_r1_level) else $error("rate1 level not applied");

  property p_r1_fine;
    aresetn && !ls0 && !rate_gen2[0] |=> q.fine[0][0] == $past(c00[7:5]) && q.de_en[0];
  endproperty
  a_r1_fine: assert property (p_r1_fine) else $error("rate1 fine not applied");

  property p_r2m_level;
    aresetn && !ls0 && rate_gen2[0] && !deemph_sel_strong[0]
      |=> q.level[0][0] == $past(c00[12:8]);
  endproperty
  a_r2m_level: assert property (p_r2m_level) else $error("mild level not applied");

  property p_r2m_fine;
    aresetn && !ls0 && rate_gen2[0] && !deemph_sel_strong[0]
      |=> q.fine[0][0] == $past(c00[15:13]);
  endproperty
  a_r2m_fine: assert property (p_r2m_fine) else $error("mild fine not applied");

  property p_r2s_level;
    aresetn && !ls0 && rate_gen2[0] && deemph_sel_strong[0]
      |=> q.level[0][0] == $past(c00[20:16]);
  endproperty
  a_r2s_level: assert property (p_r2s_level) else $error("strong level not applied");

  property p_unsel_keep;
    wr0 && !q.qctl[0][0] |=> c00 == $past(c00);
  endproperty
  a_unsel_keep: assert property (p_unsel_keep) else $error("unselected lane changed");

  property p_sel_write;
    wr0 && q.qctl[0][0] && q.w_strb == 4'hf |=> c00 == $past(q.w_data[20:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selected lane not written");

  property p_low_swing;
    ls0 |=> !q.de_en[0] && q.fine[0][0] == 3'h0 && q.level[0][0] == 5'h00
            ##1 (q.de_en[0] != $past(ls0));
  endproperty
  a_low_swing: assert property (p_low_swing) else $error("de-emphasis on in low swing");

  property p_unmapped;
    arvalid && arready && araddr[7:4] == 4'ha |=> rvalid && rresp == `RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("quad 10 not refused");

endmodule : serdes_tx_lane_level_ctrl

// file: inc/serdes_tx_lane_level_params.svh
/*
  Constants for the transmitter lane level control block: address map,
  field positions, reset values and sizes.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SERDES_TX_LANE_LEVEL_PARAMS_SVH
`define SERDES_TX_LANE_LEVEL_PARAMS_SVH

`define NUM_SLOTS        12
`define NUM_LANES        4
`define ADDR_W           8
`define LANE_CFG_W       21
`define QCTL_W           5
// quad index sits in addr[7:4], register in addr[3:2]
`define OFF_TX_LANE_CTL1 2'h0
`define OFF_QUAD_CTL     2'h1
`define QCTL_LANE_SEL_HI 3
`define QCTL_LANE_SEL_LO 0
`define QCTL_LOW_SWING   4
`define FS_LVL_R1_HI     4
`define FS_LVL_R1_LO     0
`define FDE_R1_HI        7
`define FDE_R1_LO        5
`define FS_LVL_R2M_HI    12
`define FS_LVL_R2M_LO    8
`define FDE_R2M_HI       15
`define FDE_R2M_LO       13
`define FS_LVL_R2S_HI    20
`define FS_LVL_R2S_LO    16
`define RST_FS_LVL_R1    5'h11
`define RST_FDE_R1       3'h4
`define RST_FS_LVL_R2M   5'h17
`define RST_FDE_R2M      3'h4
`define RST_FS_LVL_R2S   5'h13
`define RST_QCTL         5'h00
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: inc/serdes_tx_lane_level_pkg.sv
/*
  Types for the transmitter lane level control block.
  Assumes the params header is on the include path.
*/
`include "serdes_tx_lane_level_params.svh"

package serdes_tx_lane_level_pkg;
  typedef logic [`LANE_CFG_W-1:0] lane_cfg_t;
  typedef logic [`QCTL_W-1:0]     qctl_t;

  typedef struct packed {
    lane_cfg_t [`NUM_SLOTS-1:0][`NUM_LANES-1:0] cfg;
    qctl_t     [`NUM_SLOTS-1:0]                 qctl;
    logic                                       aw_hold;
    logic [`ADDR_W-1:0]                         aw_addr;
    logic                                       w_hold;
    logic [31:0]                                w_data;
    logic [3:0]                                 w_strb;
    logic                                       bvalid;
    logic [1:0]                                 bresp;
    logic                                       rvalid;
    logic [31:0]                                rdata;
    logic [1:0]                                 rresp;
    logic [`NUM_SLOTS-1:0][`NUM_LANES-1:0][4:0] level;
    logic [`NUM_SLOTS-1:0][`NUM_LANES-1:0][2:0] fine;
    logic [`NUM_SLOTS-1:0]                      de_en;
  } state_s;
endpackage : serdes_tx_lane_level_pkg

// file: tb/serdes_tx_lane_level_ctrl_bench.sv
/*
  Self-checking bench for the lane level block: AXI4-Lite master tasks,
  an integer model of the registers and driver settings, random traffic.
  Assumes the params header on the include path and the package compiled.
*/
`timescale 1ns/1ps
`include "serdes_tx_lane_level_params.svh"
module serdes_tx_lane_level_ctrl_bench
  import serdes_tx_lane_level_pkg::*;
;
  logic         aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]   awaddr = 8'h0, araddr = 8'h0;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [31:0]  wdata = 32'h0, rdata;
  logic [3:0]   wstrb = 4'h0;
  logic [1:0]   bresp, rresp;
  logic [11:0]  rate_gen2 = 12'h0, deemph_sel_strong = 12'h0, drv_deemph_en;
  logic [239:0] drv_level;
  logic [143:0] drv_fine_deemph;
  int           errors = 0, samples_checked = 0;
  int           m_cfg [12][4];
  int           m_q [12];
  int           quads [$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 12, 13};

  always #5 aclk = ~aclk;

  serdes_tx_lane_level_ctrl serdes_tx_lane_level_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rate_gen2(rate_gen2),
    .deemph_sel_strong(deemph_sel_strong), .drv_level(drv_level),
    .drv_fine_deemph(drv_fine_deemph), .drv_deemph_en(drv_deemph_en));

  task automatic results();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      errors++;
      results();
    end
  endtask : guard

  function automatic int slot_of(logic [7:0] a);
    int r [$];
    r = quads.find_first_index(x) with (x == int'(a[7:4]));
    return (r.size() == 0 || a[3]) ? -1 : r[0];
  endfunction : slot_of

  function automatic int merge(int old, logic [31:0] d, logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction : merge

  function automatic logic [1:0] m_write(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int sl;
    sl = slot_of(a);
    if (sl < 0) return 2'h2;
    if (a[2]) m_q[sl] = merge(m_q[sl], d, s) & 32'h1f;
    else for (int l = 0; l < 4; l++)
      if (m_q[sl][l]) m_cfg[sl][l] = merge(m_cfg[sl][l], d, s) & 32'h1fffff;
    return 2'h0;
  endfunction : m_write

  function automatic logic [33:0] m_read(logic [7:0] a);
    int sl, l;
    sl = slot_of(a);
    l = 0;
    if (sl < 0) return {2'h2, 32'h0};
    if (a[2]) return {2'h0, 32'(m_q[sl])};
    for (int i = 3; i >= 0; i--) if (m_q[sl][i]) l = i;
    return {2'h0, 32'(m_cfg[sl][l])};
  endfunction : m_read

  function automatic logic [8:0] m_drv(int sl, int l);
    logic [20:0] c;
    c = 21'(m_cfg[sl][l]);
    if (m_q[sl][4]) return 9'h0;
    if (!rate_gen2[sl]) return {1'b1, c[4:0], c[7:5]};
    if (!deemph_sel_strong[sl]) return {1'b1, c[12:8], c[15:13]};
    return {1'b1, c[20:16], 3'h0};
  endfunction : m_drv

  // both items offered together; ready seen mid-cycle equals ready at the next edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, awr, wr, bv;
    logic [1:0] br;
    int n;
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw = 1'b1; w = 1'b1; bv = 1'b0; n = 0;
    while (!bv) begin
      @(negedge aclk);
      awr = awready; wr = wready; bv = bvalid & !aw & !w; br = bresp;
      @(posedge aclk);
      if (aw && awr) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wr) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
      guard(n);
    end
    bready <= 1'b0;
    check({32'h0, br}, {32'h0, m_write(a, d, s)});
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    logic ar, arr, rv;
    logic [33:0] got;
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    ar = 1'b1; rv = 1'b0; n = 0;
    while (!rv) begin
      @(negedge aclk);
      arr = arready; rv = rvalid & !ar; got = {rresp, rdata};
      @(posedge aclk);
      if (ar && arr) begin
        arvalid <= 1'b0;
        ar = 1'b0;
      end
      guard(n);
    end
    rready <= 1'b0;
    check(got, m_read(a));
    @(posedge aclk);
  endtask : axi_read

  task automatic drv_check();
    logic [8:0] seen;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    for (int s = 0; s < 12; s++)
      for (int l = 0; l < 4; l++) begin
        seen = {drv_deemph_en[s], drv_level[s*20+l*5 +: 5], drv_fine_deemph[s*12+l*3 +: 3]};
        check({25'h0, seen}, {25'h0, m_drv(s, l)});
      end
    @(posedge aclk);
  endtask : drv_check

  initial begin
    logic [31:0] r;
    logic [7:0] a;
    int rst_word;
    rst_word = int'({`RST_FS_LVL_R2S, `RST_FDE_R2M, `RST_FS_LVL_R2M,
                     `RST_FDE_R1, `RST_FS_LVL_R1});
    for (int s = 0; s < 12; s++) begin
      m_q[s] = 0;
      for (int l = 0; l < 4; l++) m_cfg[s][l] = rst_word;
    end
    void'($urandom(70844));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 256; i += 4) axi_read(8'(i));
    $display("test reset_read done");
    for (int i = 0; i < 4; i++) begin
      rate_gen2 <= 12'($urandom);
      deemph_sel_strong <= 12'($urandom);
      drv_check();
    end
    $display("test reset_drive done");
    // software keeps first-rate fine de-emphasis at its nominal setting
    foreach (quads[k]) begin
      a = 8'(quads[k] << 4);
      axi_write(a | 8'h4, 32'h0000000f, 4'hf);
      r = $urandom;
      r[`FDE_R1_HI:`FDE_R1_LO] = `RST_FDE_R1;
      axi_write(a, r, 4'hf);
      axi_read(a);
    end
    drv_check();
    $display("test nominal_deemph done");
    for (int i = 0; i < 400; i++) begin
      r = $urandom;
      a = {r[7:4], r[3] & r[8] & r[9], r[2], 2'h0};
      if (r[10]) axi_write(a, $urandom, r[14:11]);
      else axi_read(a);
      if (i % 25 == 24) begin
        rate_gen2 <= 12'($urandom);
        deemph_sel_strong <= 12'($urandom);
        drv_check();
      end
    end
    $display("test random_traffic done");
    results();
  end
endmodule : serdes_tx_lane_level_ctrl_bench
